// [hdl/op_pkg.sv]
package op_pkg;

  // Operation select codes
  typedef enum logic [2:0] {
    OP_NONE        = 3'h0,
    OP_WIPE_WORK   = 3'h1,
    OP_WIPE_SLOT   = 3'h2,
    OP_KICK_WATCH  = 3'h3,
    OP_INVERT      = 3'h4,
    OP_COMPARE     = 3'h5,
    OP_DECREMENT   = 3'h6
  } op_code_t;

  localparam int          DATA_W       = 8;
  localparam int          ADDR_W       = 6;
  localparam int          SLOT_COUNT   = 64;
  localparam logic [7:0]  ZERO_BYTE    = 8'h00;
  localparam logic [7:0]  ONE_BYTE     = 8'h01;
  localparam logic [7:0]  WORK_RESET   = 8'h00;
  localparam logic [7:0]  SLOT_RESET   = 8'h00;
  localparam logic        TARGET_WORK  = 1'h0;
  localparam logic        TARGET_SLOT  = 1'h1;

endpackage

// [hdl/op_result_unit.sv]
// Combinational result and flag generation for one operation
module op_result_unit (
  // Operation
  input  wire op_pkg::op_code_t op,
  // Operands
  input  wire logic [7:0]       slot_value,
  input  wire logic [7:0]       work_value,
  // Results
  output logic      [7:0]       result,
  output logic                  null_flag,
  output logic                  borrow_inv,
  output logic                  sets_null,
  output logic                  sets_borrow
);

  logic [8:0] diff;

  always_comb begin
    diff        = {1'h0, slot_value} - {1'h0, work_value};
    result      = op_pkg::ZERO_BYTE;
    sets_null   = 1'h0;
    sets_borrow = 1'h0;
    borrow_inv  = 1'h0;
    case (op)
      op_pkg::OP_WIPE_WORK, op_pkg::OP_WIPE_SLOT: begin
        result    = op_pkg::ZERO_BYTE;
        sets_null = 1'h1;
      end
      op_pkg::OP_INVERT: begin
        result    = ~slot_value;
        sets_null = 1'h1;
      end
      op_pkg::OP_COMPARE: begin
        // No borrow means carry set, as in two's complement subtraction
        result      = diff[7:0];
        borrow_inv  = ~diff[8];
        sets_null   = 1'h1;
        sets_borrow = 1'h1;
      end
      op_pkg::OP_DECREMENT: begin
        result    = slot_value - op_pkg::ONE_BYTE;
        sets_null = 1'h1;
      end
      default: begin
        result = op_pkg::ZERO_BYTE;
      end
    endcase
    null_flag = (result == op_pkg::ZERO_BYTE);
  end

endmodule // op_result_unit

// [hdl/clear_invert_compare_decrement_ops.sv]
module clear_invert_compare_decrement_ops #(
  parameter int SLOTS = op_pkg::SLOT_COUNT
) (
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             rst,
  // Instruction
  input  wire logic             op_valid,
  input  wire op_pkg::op_code_t op,
  input  wire logic [5:0]       slot_addr,
  input  wire logic             result_target_bit,
  input  wire logic             prescaler_on_watch,
  // Working register and flags
  output logic      [7:0]       working_register_q,
  output logic                  result_null_flag_q,
  output logic                  borrow_inverse_bit_q,
  output logic                  timeout_status_q,
  output logic                  powerdown_status_q,
  // Watch timer kicks
  output logic                  watch_timer_clear,
  output logic                  shared_prescaler_clear,
  // Slot read-back
  output logic      [7:0]       slot_data
);

  // The six-bit slot index serves exactly this many slots, no more and no fewer
  if (SLOTS != op_pkg::SLOT_COUNT) begin : g_bad_slots
    $error("SLOTS must be 64");
  end

  ////////////////////////////////////////////////////////////////////////////
  logic [7:0] slot_mem_q [SLOTS];
  logic [7:0] result;
  logic       null_flag;
  logic       borrow_inv;
  logic       sets_null;
  logic       sets_borrow;
  logic       go;
  logic       to_slot;
  logic       to_work;

  // Six-bit index covers all 64 slots directly
  assign slot_data = slot_mem_q[slot_addr];
  assign go        = op_valid;

  op_result_unit u_result (
    .op          (op),
    .slot_value  (slot_data),
    .work_value  (working_register_q),
    .result      (result),
    .null_flag   (null_flag),
    .borrow_inv  (borrow_inv),
    .sets_null   (sets_null),
    .sets_borrow (sets_borrow)
  );

  // Routing; compare never writes back
  always_comb begin
    to_slot = 1'h0;
    to_work = 1'h0;
    case (op)
      op_pkg::OP_WIPE_WORK: to_work = 1'h1;
      op_pkg::OP_WIPE_SLOT: to_slot = 1'h1;
      op_pkg::OP_INVERT, op_pkg::OP_DECREMENT: begin
        to_slot = (result_target_bit == op_pkg::TARGET_SLOT);
        to_work = (result_target_bit == op_pkg::TARGET_WORK);
      end
      default: begin
        to_slot = 1'h0;
        to_work = 1'h0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Single-cycle update, no stall path exists
  always_ff @(posedge clock) begin
    if (rst) begin
      working_register_q <= op_pkg::WORK_RESET;
    end else if (go && to_work) begin
      working_register_q <= result;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      for (int i = 0; i < SLOTS; i++) begin
        slot_mem_q[i] <= op_pkg::SLOT_RESET;
      end
    end else if (go && to_slot) begin
      slot_mem_q[slot_addr] <= result;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      result_null_flag_q   <= 1'h0;
      borrow_inverse_bit_q <= 1'h0;
    end else if (go) begin
      if (sets_null) begin
        result_null_flag_q <= null_flag;
      end
      if (sets_borrow) begin
        borrow_inverse_bit_q <= borrow_inv;
      end
    end
  end

  // Status bits reset high here; power-on events are handled elsewhere
  always_ff @(posedge clock) begin
    if (rst) begin
      timeout_status_q   <= 1'h1;
      powerdown_status_q <= 1'h1;
    end else if (go && op == op_pkg::OP_KICK_WATCH) begin
      timeout_status_q   <= 1'h1;
      powerdown_status_q <= 1'h1;
    end
  end

  // Kick pulses are combinational so the counter clears in the same cycle
  always_comb begin
    watch_timer_clear      = go && (op == op_pkg::OP_KICK_WATCH);
    shared_prescaler_clear = watch_timer_clear && prescaler_on_watch;
  end

  ////////////////////////////////////////////////////////////////////////////
  wipe_work_a: assert property (@(posedge clock) disable iff (rst)
    go && op == op_pkg::OP_WIPE_WORK |=> working_register_q == 8'h00 && result_null_flag_q)
    else $error("wipe working failed");

  wipe_slot_a: assert property (@(posedge clock) disable iff (rst)
    go && op == op_pkg::OP_WIPE_SLOT ##1 op_valid == 1'h0 && slot_addr == $past(slot_addr)
    |-> slot_data == 8'h00 && result_null_flag_q)
    else $error("wipe slot failed");

  prescaler_kick_a: assert property (@(posedge clock) disable iff (rst)
    shared_prescaler_clear == (op_valid && op == op_pkg::OP_KICK_WATCH && prescaler_on_watch))
    else $error("prescaler clear wrong");

  watch_kick_a: assert property (@(posedge clock) disable iff (rst)
    watch_timer_clear == (op_valid && op == op_pkg::OP_KICK_WATCH))
    else $error("watch timer clear wrong");

  status_kick_a: assert property (@(posedge clock) disable iff (rst)
    go && op == op_pkg::OP_KICK_WATCH |=> timeout_status_q && powerdown_status_q
    && $stable(result_null_flag_q) && $stable(borrow_inverse_bit_q))
    else $error("kick status wrong");

  invert_work_a: assert property (@(posedge clock) disable iff (rst)
    go && op == op_pkg::OP_INVERT && !result_target_bit
    |=> working_register_q == ~$past(slot_data)
    && result_null_flag_q == (working_register_q == 8'h00))
    else $error("invert to working wrong");

  target_slot_a: assert property (@(posedge clock) disable iff (rst)
    go && (op == op_pkg::OP_INVERT || op == op_pkg::OP_DECREMENT) && result_target_bit
    |=> $stable(working_register_q))
    else $error("working changed on slot target");

  compare_flag_a: assert property (@(posedge clock) disable iff (rst)
    go && op == op_pkg::OP_COMPARE
    |=> borrow_inverse_bit_q == ($past(slot_data) >= $past(working_register_q))
    && result_null_flag_q == ($past(slot_data) == $past(working_register_q)))
    else $error("compare flags wrong");

  compare_keep_a: assert property (@(posedge clock) disable iff (rst)
    go && op == op_pkg::OP_COMPARE |=> $stable(working_register_q))
    else $error("compare modified working register");

  decrement_work_a: assert property (@(posedge clock) disable iff (rst)
    go && op == op_pkg::OP_DECREMENT && !result_target_bit
    |=> working_register_q == 8'($past(slot_data) - 8'h01))
    else $error("decrement result wrong");

  decrement_null_a: assert property (@(posedge clock) disable iff (rst)
    go && op == op_pkg::OP_DECREMENT
    |=> result_null_flag_q == ($past(slot_data) == 8'h01))
    else $error("decrement zero flag wrong");

  // Slot checks need one idle edge at the same index, since slot_data follows slot_addr
  invert_slot_a: assert property (@(posedge clock) disable iff (rst)
    go && op == op_pkg::OP_INVERT && result_target_bit
    ##1 !op_valid && slot_addr == $past(slot_addr)
    |-> slot_data == ~$past(slot_data) && result_null_flag_q == (slot_data == 8'h00))
    else $error("invert to slot wrong");

  decrement_slot_a: assert property (@(posedge clock) disable iff (rst)
    go && op == op_pkg::OP_DECREMENT && result_target_bit
    ##1 !op_valid && slot_addr == $past(slot_addr)
    |-> slot_data == 8'($past(slot_data) - 8'h01))
    else $error("decrement to slot wrong");

  target_work_a: assert property (@(posedge clock) disable iff (rst)
    go && (op == op_pkg::OP_INVERT || op == op_pkg::OP_DECREMENT) && !result_target_bit
    ##1 !op_valid && slot_addr == $past(slot_addr)
    |-> $stable(slot_data))
    else $error("slot changed on working target");

  compare_slot_a: assert property (@(posedge clock) disable iff (rst)
    go && op == op_pkg::OP_COMPARE ##1 !op_valid && slot_addr == $past(slot_addr)
    |-> $stable(slot_data))
    else $error("compare modified slot");

  wipe_keep_a: assert property (@(posedge clock) disable iff (rst)
    go && op == op_pkg::OP_WIPE_SLOT |=> $stable(working_register_q))
    else $error("slot wipe modified working register");

  kick_keep_a: assert property (@(posedge clock) disable iff (rst)
    go && op == op_pkg::OP_KICK_WATCH |=> $stable(working_register_q))
    else $error("kick modified working register");

  // Carry belongs to compare alone, so other operations must leave it as it was
  carry_keep_a: assert property (@(posedge clock) disable iff (rst)
    go && op != op_pkg::OP_COMPARE |=> $stable(borrow_inverse_bit_q))
    else $error("carry changed outside compare");

  idle_keep_a: assert property (@(posedge clock) disable iff (rst)
    !op_valid |=> $stable(working_register_q) && $stable(result_null_flag_q))
    else $error("state changed with no operation");

endmodule // clear_invert_compare_decrement_ops

// [tb/tb_clear_invert_compare_decrement_ops.sv]
module tb_clear_invert_compare_decrement_ops;
  timeunit 1ns;
  timeprecision 1ps;

  ////////////////////////////////////////////////////////////////////////////////
  logic             clock;
  logic             rst;
  logic             op_valid;
  op_pkg::op_code_t op;
  logic [5:0]       addr;
  logic             target;
  logic             on_watch;
  logic [7:0]       work;
  logic [7:0]       slot;
  logic             null_f;
  logic             borrow_f;
  logic             tout;
  logic             pdown;
  logic             wclr;
  logic             pclr;
  int               errors;
  int               n_compared;

  clear_invert_compare_decrement_ops DUT (
    .clock(clock), .rst(rst), .op_valid(op_valid), .op(op), .slot_addr(addr),
    .result_target_bit(target), .prescaler_on_watch(on_watch),
    .working_register_q(work), .result_null_flag_q(null_f),
    .borrow_inverse_bit_q(borrow_f), .timeout_status_q(tout),
    .powerdown_status_q(pdown), .watch_timer_clear(wclr),
    .shared_prescaler_clear(pclr), .slot_data(slot)
  );

  initial begin
    clock = 1'h0;
    forever #20 clock = ~clock;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up();
    $display("errors=%0d compared=%0d", errors, n_compared);
    if (errors == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // Inputs move on the falling edge so the rising edge never races them
  task automatic issue(input op_pkg::op_code_t o, input logic [5:0] a, input logic t);
    @(negedge clock);
    op = o;
    addr = a;
    target = t;
    op_valid = 1'h1;
  endtask

  task automatic run(input op_pkg::op_code_t o, input logic [5:0] a, input logic t);
    issue(o, a, t);
    @(negedge clock);
    op_valid = 1'h0;
    op = op_pkg::OP_NONE;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_decrement();
    run(op_pkg::OP_DECREMENT, 6'h3f, 1'h1);
    chk(slot, 8'hff);
    chk({7'h00, null_f}, 8'h00);
    chk(work, 8'h00);
    run(op_pkg::OP_DECREMENT, 6'h3f, 1'h0);
    chk(work, 8'hfe);
    chk(slot, 8'hff);
    // Walk slot 0x20 down to 0xfe, then invert it to one so a decrement lands on zero
    run(op_pkg::OP_DECREMENT, 6'h20, 1'h1);
    run(op_pkg::OP_DECREMENT, 6'h20, 1'h1);
    run(op_pkg::OP_INVERT, 6'h20, 1'h1);
    run(op_pkg::OP_DECREMENT, 6'h20, 1'h0);
    chk(work, 8'h00);
    chk({7'h00, null_f}, 8'h01);
    chk(slot, 8'h01);
  endtask

  task automatic t_invert();
    run(op_pkg::OP_INVERT, 6'h3f, 1'h1);
    chk(slot, 8'h00);
    chk({7'h00, null_f}, 8'h01);
    run(op_pkg::OP_INVERT, 6'h3f, 1'h0);
    chk(work, 8'hff);
    chk({7'h00, null_f}, 8'h00);
    chk(slot, 8'h00);
  endtask

  // Equal, borrow and no-borrow cases; the slot is checked after the first two, the working register after the second
  task automatic t_compare();
    run(op_pkg::OP_DECREMENT, 6'h05, 1'h1);
    run(op_pkg::OP_COMPARE, 6'h05, 1'h1);
    chk({6'h00, null_f, borrow_f}, 8'h03);
    chk(slot, 8'hff);
    run(op_pkg::OP_COMPARE, 6'h3f, 1'h0);
    chk({6'h00, null_f, borrow_f}, 8'h00);
    chk(work, 8'hff);
    chk(slot, 8'h00);
    run(op_pkg::OP_WIPE_WORK, 6'h3f, 1'h0);
    chk({work[6:0], null_f}, 8'h01);
    run(op_pkg::OP_COMPARE, 6'h05, 1'h0);
    chk({6'h00, null_f, borrow_f}, 8'h01);
  endtask

  task automatic t_wipe_slot();
    run(op_pkg::OP_NONE, 6'h05, 1'h1);
    chk(slot, 8'hff);
    chk({6'h00, null_f, borrow_f}, 8'h01);
    run(op_pkg::OP_WIPE_SLOT, 6'h05, 1'h0);
    chk(slot, 8'h00);
    chk({7'h00, null_f}, 8'h01);
  endtask

  task automatic t_kick();
    // Zero flag low and carry high first, so an unwanted flag change shows
    run(op_pkg::OP_DECREMENT, 6'h00, 1'h1);
    issue(op_pkg::OP_KICK_WATCH, 6'h00, 1'h0);
    #1 chk({6'h00, wclr, pclr}, 8'h02);
    on_watch = 1'h1;
    #1 chk({6'h00, wclr, pclr}, 8'h03);
    run(op_pkg::OP_KICK_WATCH, 6'h00, 1'h0);
    chk({4'h0, tout, pdown, null_f, borrow_f}, 8'h0d);
    chk(slot, 8'hff);
    #1 chk({6'h00, wclr, pclr}, 8'h00);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    errors = 0;
    n_compared = 0;
    rst = 1'h1;
    op_valid = 1'h0;
    op = op_pkg::OP_NONE;
    addr = 6'h00;
    target = 1'h0;
    on_watch = 1'h0;
    repeat (12) @(posedge clock);
    @(negedge clock);
    rst = 1'h0;
    t_decrement();
    t_invert();
    t_compare();
    t_wipe_slot();
    t_kick();
    wrap_up();
  end

  // The tests need well under 100 cycles
  initial begin
    repeat (2000) @(posedge clock);
    errors++;
    wrap_up();
  end

endmodule // tb_clear_invert_compare_decrement_ops
